// ===== verilog/ipdis_decoder.sv
// Host I/O decoder and shared interrupt logic of an eight-port serial card.
// Assumes all inputs are asynchronous pins (bus, switches, jumpers, UART irqs).
`timescale 1ns/10ps
`include "ipdis_cfg.svh"

module ipdis_decoder
	import ipdis_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [`IPDIS_ADDR_W-1:0] host_addr,
	input wire logic host_aen,
	input wire logic host_ior_n,
	input wire logic host_iow_n,
	input wire logic [6:0] base_sw_off,
	input wire logic [`IPDIS_CHAN_N-1:0] chan_irq,
	input wire logic [`IPDIS_CHAN_N-1:0][`IPDIS_LEVEL_W-1:0] irq_jumper,
	input wire logic slot_8bit,
	output logic [`IPDIS_CHAN_N-1:0] chan_cs_n,
	output logic [`IPDIS_REG_W-1:0] chan_reg_sel,
	output logic [7:0] status_rd_data,
	output logic status_rd_oe,
	output logic [`IPDIS_LEVEL_N-1:0] host_irq
);

	ipdis_state_s st_q;
	ipdis_state_s st_d;
	logic [`IPDIS_LEVEL_N-1:0] lvl_or;

	// ----------------------------------------
	// Level routing
	// ----------------------------------------
	genvar gl;
	generate
		for (gl = 0; gl < `IPDIS_LEVEL_N; gl++) begin : g_lvl
			logic [`IPDIS_CHAN_N-1:0] hit;
			for (genvar gc = 0; gc < `IPDIS_CHAN_N; gc++) begin : g_ch
				assign hit[gc] = st_q.chirq_s[gc] && (st_q.jmp_s[gc] == ipdis_level_t'(gl));
			end
			// Only levels 2-7 and 10-15 without 13 exist on the card
			if ((gl >= 2 && gl <= 7) || (gl >= 10 && gl <= 15 && gl != 13)) begin : g_ok
				if (gl >= `IPDIS_LVL_UPPER) begin : g_up
					assign lvl_or[gl] = |hit && !st_q.slot8_s;
				end else begin : g_lo
					assign lvl_or[gl] = |hit;
				end
			end else begin : g_none
				assign lvl_or[gl] = 1'b0;
			end
		end
	endgenerate

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	always_comb begin
		logic [6:0] ofs;
		logic base_ok;
		logic in_win;
		logic stat_hit;
		logic access;
		ofs = 7'h00;
		base_ok = 1'b0;
		in_win = 1'b0;
		stat_hit = 1'b0;
		access = 1'b0;
		st_d = st_q;
		// Two-flop synchronisers on every pin
		st_d.addr_m = host_addr;
		st_d.addr_s = st_q.addr_m;
		st_d.ctl_m = '{aen: host_aen, ior_n: host_ior_n, iow_n: host_iow_n};
		st_d.ctl_s = st_q.ctl_m;
		st_d.sw_m = base_sw_off;
		st_d.sw_s = st_q.sw_m;
		st_d.chirq_m = chan_irq;
		st_d.chirq_s = st_q.chirq_m;
		st_d.jmp_m = irq_jumper;
		st_d.jmp_s = st_q.jmp_m;
		st_d.slot8_m = slot_8bit;
		st_d.slot8_s = st_q.slot8_m;
		// Switch off counts as one, so the synced level is the base directly
		ofs = 7'(st_q.addr_s[9:3] - st_q.sw_s);
		base_ok = st_q.sw_s >= `IPDIS_BASE_MIN;
		in_win = base_ok && (st_q.addr_s[15:10] == 6'h00) && (st_q.addr_s[9:3] >= st_q.sw_s)
			&& (ofs < `IPDIS_CHAN_SPAN);
		stat_hit = base_ok && ((st_q.addr_s & ~16'h0007) == ({6'h00, st_q.sw_s, 3'h0} | `IPDIS_STATUS_OFS));
		access = !st_q.ctl_s.aen && !(st_q.ctl_s.ior_n && st_q.ctl_s.iow_n);
		st_d.cs_n = `IPDIS_CS_N_RST;
		if (access && in_win) begin
			st_d.cs_n[ofs[2:0]] = 1'b0;
		end
		st_d.reg_sel = st_q.addr_s[2:0];
		st_d.rd_oe = 1'b0;
		st_d.rd_data = `IPDIS_DATA_RST;
		// Writes to the status address are ignored
		if (!st_q.ctl_s.aen && !st_q.ctl_s.ior_n && stat_hit) begin
			st_d.rd_oe = 1'b1;
			st_d.rd_data = st_q.chirq_s;
		end
		st_d.irq = lvl_or;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
			st_q.cs_n <= `IPDIS_CS_N_RST;
			st_q.ctl_m <= '{aen: 1'b1, ior_n: 1'b1, iow_n: 1'b1};
			st_q.ctl_s <= '{aen: 1'b1, ior_n: 1'b1, iow_n: 1'b1};
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign chan_cs_n = st_q.cs_n;
	assign chan_reg_sel = st_q.reg_sel;
	assign status_rd_data = st_q.rd_data;
	assign status_rd_oe = st_q.rd_oe;
	assign host_irq = st_q.irq;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_cs_onehot: assert property ($onehot0(~chan_cs_n)) else $error("more than one channel selected");
	a_low_base: assert property ($past(st_q.sw_s) < `IPDIS_BASE_MIN |-> &chan_cs_n && !status_rd_oe)
		else $error("decode with base below window");
	a_cs_window: assert property (!chan_cs_n[0] |-> $past(st_q.addr_s[9:3]) == $past(st_q.sw_s)
		&& $past(st_q.addr_s[15:10]) == 6'h00) else $error("channel zero off its base");
	a_ch7_offset: assert property (!chan_cs_n[7]
		|-> $past(st_q.addr_s[9:3]) == 7'($past(st_q.sw_s) + 7'h07))
		else $error("channel seven not at base plus 0x38");
	a_reg_select: assert property (!(&chan_cs_n) |-> chan_reg_sel == $past(st_q.addr_s[2:0]))
		else $error("register select not low address");
	a_status_addr: assert property (status_rd_oe |-> $past(st_q.addr_s[`IPDIS_STATUS_BIT])
		&& $past(st_q.addr_s[15:11]) == 5'h00
		&& $past(st_q.addr_s[9:3]) == $past(st_q.sw_s) && !$past(st_q.ctl_s.ior_n))
		else $error("status read off its address");
	a_status_data: assert property (status_rd_oe
		|-> status_rd_data == $past(st_q.chirq_s, 1) && &chan_cs_n)
		else $error("status data not channel requests");
	a_irq13_none: assert property (host_irq[13] == 1'b0
		&& host_irq[1:0] == 2'b00 && host_irq[9:8] == 2'b00)
		else $error("request on an unsupported level");
	a_slot8_upper: assert property ($past(st_q.slot8_s) |-> host_irq[15:8] == 8'h00)
		else $error("upper level in eight-bit slot");
	a_shared_line: assert property ($past(st_q.chirq_s[0])
		&& $past(st_q.jmp_s[0]) == 4'h5 |-> host_irq[5])
		else $error("channel request lost on shared line");
	a_data_idle: assert property (!status_rd_oe |-> status_rd_data == `IPDIS_DATA_RST)
		else $error("status data driven while idle");
	a_dma_ignored: assert property ($past(st_q.ctl_s.aen) |-> &chan_cs_n && !status_rd_oe)
		else $error("decode during a DMA cycle");
	a_cs_release: assert property ($past(st_q.ctl_s.ior_n) && $past(st_q.ctl_s.iow_n) |-> &chan_cs_n)
		else $error("channel selected with no strobe");
	a_status_write: assert property ($past(st_q.ctl_s.ior_n) |-> !status_rd_oe)
		else $error("status driven on a write");
	a_window_hit: assert property (!$past(st_q.ctl_s.aen) && !$past(st_q.ctl_s.ior_n)
		&& $past(st_q.sw_s) >= `IPDIS_BASE_MIN && $past(st_q.addr_s[15:10]) == 6'h00
		&& $past(st_q.addr_s[9:3]) >= $past(st_q.sw_s)
		&& 7'($past(st_q.addr_s[9:3]) - $past(st_q.sw_s)) < `IPDIS_CHAN_SPAN |-> !(&chan_cs_n))
		else $error("read inside window selects nothing");
	a_status_hit: assert property (!$past(st_q.ctl_s.aen) && !$past(st_q.ctl_s.ior_n)
		&& $past(st_q.sw_s) >= `IPDIS_BASE_MIN
		&& $past(st_q.addr_s[15:3]) == {5'h00, 1'b1, $past(st_q.sw_s)} |-> status_rd_oe)
		else $error("status read not answered");
	a_irq_source: assert property (host_irq != 16'h0000 |-> $past(st_q.chirq_s) != 8'h00)
		else $error("level raised with no channel request");
	a_sel_follow: assert property (chan_reg_sel == $past(st_q.addr_s[2:0]))
		else $error("register select does not follow address");
	a_cs_base_min: assert property (!(&chan_cs_n) |-> $past(st_q.addr_s[9:3]) >= `IPDIS_BASE_MIN)
		else $error("channel selected below the base range");
	a_chan_idle: assert property ($past(st_q.addr_s[15:10]) != 6'h00 |-> &chan_cs_n)
		else $error("channel selected with high address bits");
	a_status_base: assert property (status_rd_oe |-> $past(st_q.sw_s) >= `IPDIS_BASE_MIN)
		else $error("status answered with base below window");

	// ----------------------------------------
	// Per-channel checks
	// ----------------------------------------
	for (genvar gc = 0; gc < `IPDIS_CHAN_N; gc++) begin : g_chk
		a_chan_offset: assert property (@(posedge clk) disable iff (!rst_n) !chan_cs_n[gc]
			|-> 7'($past(st_q.addr_s[9:3]) - $past(st_q.sw_s)) == 7'(gc))
			else $error("channel select off its block");
		a_route_low: assert property (@(posedge clk) disable iff (!rst_n) $past(st_q.chirq_s[gc])
			&& $past(st_q.jmp_s[gc]) inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7}
			|-> host_irq[$past(st_q.jmp_s[gc])])
			else $error("request missing on a low level");
		a_route_high: assert property (@(posedge clk) disable iff (!rst_n) $past(st_q.chirq_s[gc])
			&& !$past(st_q.slot8_s) && $past(st_q.jmp_s[gc]) inside {4'hA, 4'hB, 4'hC, 4'hE, 4'hF}
			|-> host_irq[$past(st_q.jmp_s[gc])])
			else $error("request missing on an upper level");
	end

	// ----------------------------------------
	// Covers
	// ----------------------------------------
	c_status_read: cover property (status_rd_oe ##1 !status_rd_oe);
	c_last_channel: cover property (!chan_cs_n[7]);
	c_shared_two: cover property (host_irq[5] && $past(st_q.chirq_s[1:0]) == 2'b11
		&& $past(st_q.jmp_s[0]) == 4'h5 && $past(st_q.jmp_s[1]) == 4'h5);
	c_upper_level: cover property (host_irq[15]);
	c_dma_refused: cover property ($past(st_q.ctl_s.aen) && !$past(st_q.ctl_s.ior_n));

endmodule

// ===== verilog/ipdis_cfg.svh
// Address, interrupt level and reset constants of the port decoder.
// Assumes inclusion by bare name from the package and the decoder.
`ifndef IPDIS_CFG_SVH
`define IPDIS_CFG_SVH

// ----------------------------------------
// Address map
// ----------------------------------------
`define IPDIS_ADDR_W 16
`define IPDIS_BASE_MIN 7'h20
`define IPDIS_STATUS_OFS 16'h0400
`define IPDIS_STATUS_BIT 10
`define IPDIS_CHAN_N 8
`define IPDIS_CHAN_SPAN 7'h08
`define IPDIS_REG_W 3

// ----------------------------------------
// Interrupt levels
// ----------------------------------------
`define IPDIS_LEVEL_N 16
`define IPDIS_LEVEL_W 4
`define IPDIS_LVL_UPPER 8
`define IPDIS_LVL_EXCL 4'hD

// ----------------------------------------
// Reset values
// ----------------------------------------
`define IPDIS_CS_N_RST 8'hFF
`define IPDIS_DATA_RST 8'h00

`endif

// ===== verilog/ipdis_pkg.sv
// Types shared by the port decoder.
// Assumes ipdis_cfg.svh is on the include path.
`include "ipdis_cfg.svh"

package ipdis_pkg;

	// Host bus strobes as seen at the card edge
	typedef struct packed {
		logic aen;
		logic ior_n;
		logic iow_n;
	} ipdis_ctl_s;

	typedef logic [`IPDIS_LEVEL_W-1:0] ipdis_level_t;

	// Whole decoder state, synchronisers and outputs
	typedef struct packed {
		logic [`IPDIS_ADDR_W-1:0] addr_m;
		logic [`IPDIS_ADDR_W-1:0] addr_s;
		ipdis_ctl_s ctl_m;
		ipdis_ctl_s ctl_s;
		logic [6:0] sw_m;
		logic [6:0] sw_s;
		logic [`IPDIS_CHAN_N-1:0] chirq_m;
		logic [`IPDIS_CHAN_N-1:0] chirq_s;
		logic [`IPDIS_CHAN_N-1:0][`IPDIS_LEVEL_W-1:0] jmp_m;
		logic [`IPDIS_CHAN_N-1:0][`IPDIS_LEVEL_W-1:0] jmp_s;
		logic slot8_m;
		logic slot8_s;
		logic [`IPDIS_CHAN_N-1:0] cs_n;
		logic [`IPDIS_REG_W-1:0] reg_sel;
		logic [7:0] rd_data;
		logic rd_oe;
		logic [`IPDIS_LEVEL_N-1:0] irq;
	} ipdis_state_s;

endpackage

// ===== dv/ipdis_host.sv
// Host I/O bus master model for the port decoder.
// Assumes a free-running clock; drives at the falling edge.
`timescale 1ns/10ps
`include "ipdis_cfg.svh"

module ipdis_host (
	input wire logic clk,
	output logic [`IPDIS_ADDR_W-1:0] addr,
	output logic aen,
	output logic ior_n,
	output logic iow_n
);
	initial begin
		addr = 16'h0000;
		aen = 1'b0;
		ior_n = 1'b1;
		iow_n = 1'b1;
	end
	// Start a cycle, hold it past the decode latency
	task automatic start(input logic [`IPDIS_ADDR_W-1:0] a, input logic rd, input logic dma);
		@(negedge clk);
		addr = a;
		aen = dma;
		ior_n = !rd;
		iow_n = rd;
		repeat (4) @(negedge clk);
	endtask
	// Release, released lines show no stale address
	task automatic stop();
		ior_n = 1'b1;
		iow_n = 1'b1;
		aen = 1'b0;
		addr = ~addr;
		repeat (4) @(negedge clk);
	endtask
endmodule

// ===== dv/tb_isa_port_decode_irq_share.sv
// Self-checking bench of the port decoder.
// Assumes ipdis_host as bus master; bench drives pins at the falling edge.
`timescale 1ns/10ps

module tb_isa_port_decode_irq_share;
	import ipdis_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] ha;
	logic aen, ior_n, iow_n;
	logic slot = 1'b0;
	logic [6:0] sw = 7'h5B;
	logic [7:0] cirq = 8'h00;
	logic [7:0][3:0] jmp = '0;
	logic [7:0] cs_n, rdat;
	logic [2:0] rsel;
	logic oe;
	logic [15:0] hirq;
	int fail_count = 0;
	int total_checks = 0;
	always #12.5 clk = ~clk;
	ipdis_host host (.clk(clk), .addr(ha), .aen(aen), .ior_n(ior_n), .iow_n(iow_n));
	ipdis_decoder dut (.clk(clk), .rst_n(rst_n), .host_addr(ha), .host_aen(aen), .host_ior_n(ior_n),
		.host_iow_n(iow_n), .base_sw_off(sw), .chan_irq(cirq), .irq_jumper(jmp), .slot_8bit(slot),
		.chan_cs_n(cs_n), .chan_reg_sel(rsel), .status_rd_data(rdat), .status_rd_oe(oe), .host_irq(hirq));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		if (fail_count == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		// Each channel and register from a switch base
		for (int i = 0; i < 8; i++) begin
			host.start(16'h02D8 + 16'(i * 9), !i[0], 1'b0);
			chk(cs_n, 8'(~(8'h01 << i)));
			chk(rsel, 16'(i));
			host.stop();
		end
		// Past the window, then a DMA cycle
		for (int j = 0; j < 2; j++) begin
			host.start(j ? 16'h02D8 : 16'h0318, 1'b1, j[0]);
			chk(cs_n, 8'hFF);
			host.stop();
		end
		sw = 7'h1F;
		host.start(16'h00F8, 1'b1, 1'b0);
		chk(cs_n, 8'hFF);
		host.stop();
		sw = 7'h7F;
		host.start(16'h03FF, 1'b1, 1'b0);
		chk(cs_n, 8'hFE);
		chk(rsel, 16'h0007);
		host.stop();
		// Status twice, then a write
		sw = 7'h20;
		cirq = 8'hA5;
		for (int k = 0; k < 3; k++) begin
			host.start(16'h0507, k < 2, 1'b0);
			chk(oe, k < 2);
			chk(rdat, k < 2 ? 16'h00A5 : 16'h0000);
			chk(cs_n, 8'hFF);
			host.stop();
		end
		// One level per channel, excluded and upper ones
		jmp = {4'h5, 4'h8, 4'h1, 4'hD, 4'hF, 4'hA, 4'h7, 4'h2};
		cirq = 8'hFF;
		repeat (4) @(negedge clk);
		chk(hirq, 16'h84A4);
		slot = 1'b1;
		repeat (4) @(negedge clk);
		chk(hirq, 16'h00A4);
		cirq = 8'h02;
		repeat (4) @(negedge clk);
		chk(hirq, 16'h0080);
		tally_and_finish();
	end
endmodule
